// file: design/uabw_core.sv
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Behaviour
// - overflow of the baud counter before fifth rising edge sets overflow flag
// - detection counter is 16 bits wide, overflow past all ones
// - counter overflow also sets the receive interrupt flag
// - after overflow the counter keeps counting until the fifth rising edge
// - idle flag reads zero during detection, set at the fifth rising edge
// - data read after overflow lets the fifth edge set receive flag again
// - detection cancelled early: later falling edges start ordinary reception
// - in sleep the baud generator stops, no ordinary reception happens
// - wake enable blocks ordinary reception and watches the line for wake
// - wake event is a falling edge on the receive line
// - wake on break works only in asynchronous mode
// - wake event raises the receive interrupt
// - reading the data register clears the wake interrupt condition
// - rising edge ending the break clears wake enable, receiver goes idle
// - non-zero character: first low time is the wake, rest is a fragment
module uabw_core (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mclk_en,
  input wire uabw_pkg::uabw_axi_req_type axi_in,
  output uabw_pkg::uabw_axi_rsp_type axi_out,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  output logic irq
);

  typedef struct packed {
    uabw_pkg::uabw_mode_type mode;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic slp_meta;
    logic slp_sync;
    logic ovf;
    logic wake_on_break_enable;
    logic autobaud_enable;
    logic sync_mode;
    logic receive_irq_flag;
    logic [15:0] divisor;
    logic [7:0] rx_data;
    logic [7:0] shift;
    logic [15:0] timer;
    logic [3:0] bit_idx;
    logic abd_started;
    logic [2:0] rise_cnt;
    logic [15:0] abd_count;
    logic [uabw_pkg::EV_W-1:0] ev_status;
    logic [uabw_pkg::EV_W-1:0] ev_enable;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } uabw_state_type;

  uabw_state_type st;
  uabw_state_type next_st;
  logic wr_take;
  logic rd_take;
  logic rx_fall;
  logic rx_rise;
  logic run;
  logic idle_flag;

  // bus handshakes, frozen with the clock enable
  assign wr_take = mclk_en & axi_in.awvalid & axi_in.wvalid & ~st.bvalid;
  assign rd_take = mclk_en & axi_in.arvalid & ~st.rvalid;
  assign axi_out.awready = wr_take;
  assign axi_out.wready = wr_take;
  assign axi_out.bvalid = st.bvalid;
  assign axi_out.bresp = st.bresp;
  assign axi_out.arready = rd_take;
  assign axi_out.rvalid = st.rvalid;
  assign axi_out.rresp = st.rresp;
  assign axi_out.rdata = st.rdata;

  // line edges on the synchronised copy only
  assign rx_fall = st.rx_prev & ~st.rx_sync;
  assign rx_rise = ~st.rx_prev & st.rx_sync;
  assign run = ~st.slp_sync;
  assign idle_flag = (st.mode == uabw_pkg::ST_IDLE) | (st.mode == uabw_pkg::ST_WAKE);

  // one interrupt line from enabled sticky events
  assign irq = |(st.ev_status & st.ev_enable);

  // next state
  always_comb begin
    logic [uabw_pkg::EV_W-1:0] ev;
    logic [uabw_pkg::EV_W-1:0] ev_clr;
    ev = '0;
    ev_clr = '0;
    next_st = st;
    next_st.rx_meta = rx_pin;
    next_st.rx_sync = st.rx_meta;
    next_st.rx_prev = st.rx_sync;
    next_st.slp_meta = sleep_mode;
    next_st.slp_sync = st.slp_meta;

    // write channel: both address and data taken together
    if (st.bvalid & axi_in.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_take) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = uabw_pkg::RESP_OKAY;
      unique case (axi_in.awaddr)
        uabw_pkg::OFS_BAUD_CTRL: begin
          if (axi_in.wstrb[0]) begin
            next_st.wake_on_break_enable = axi_in.wdata[uabw_pkg::BC_WUE];
            next_st.autobaud_enable = axi_in.wdata[uabw_pkg::BC_AUTOBAUD_ENABLE];
            if (!axi_in.wdata[uabw_pkg::BC_OVF]) begin
              next_st.ovf = 1'b0;
            end
          end
        end
        uabw_pkg::OFS_DIVISOR: begin
          if (axi_in.wstrb[0]) begin
            next_st.divisor[7:0] = axi_in.wdata[7:0];
          end
          if (axi_in.wstrb[1]) begin
            next_st.divisor[15:8] = axi_in.wdata[15:8];
          end
        end
        uabw_pkg::OFS_MODE: begin
          if (axi_in.wstrb[0]) begin
            next_st.sync_mode = axi_in.wdata[uabw_pkg::MODE_SYNC];
          end
        end
        uabw_pkg::OFS_EV_CLEAR: begin
          if (axi_in.wstrb[0]) begin
            ev_clr = axi_in.wdata[uabw_pkg::EV_W-1:0];
          end
        end
        uabw_pkg::OFS_EV_ENABLE: begin
          if (axi_in.wstrb[0]) begin
            next_st.ev_enable = axi_in.wdata[uabw_pkg::EV_W-1:0];
          end
        end
        uabw_pkg::OFS_RX_DATA, uabw_pkg::OFS_RX_FLAGS, uabw_pkg::OFS_EV_STATUS: begin
          next_st.bresp = uabw_pkg::RESP_OKAY; // read-only, write ignored
        end
        default: begin
          next_st.bresp = uabw_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read channel, data registered
    if (st.rvalid & axi_in.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = uabw_pkg::RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case (axi_in.araddr)
        uabw_pkg::OFS_BAUD_CTRL: begin
          next_st.rdata[uabw_pkg::BC_OVF] = st.ovf;
          next_st.rdata[uabw_pkg::BC_IDLE] = idle_flag;
          next_st.rdata[uabw_pkg::BC_WUE] = st.wake_on_break_enable;
          next_st.rdata[uabw_pkg::BC_AUTOBAUD_ENABLE] = st.autobaud_enable;
        end
        uabw_pkg::OFS_RX_DATA: begin
          next_st.rdata[7:0] = st.rx_data;
          next_st.receive_irq_flag = 1'b0;
        end
        uabw_pkg::OFS_DIVISOR: begin
          next_st.rdata[15:0] = st.divisor;
        end
        uabw_pkg::OFS_MODE: begin
          next_st.rdata[uabw_pkg::MODE_SYNC] = st.sync_mode;
        end
        uabw_pkg::OFS_RX_FLAGS: begin
          next_st.rdata[uabw_pkg::RXF_IRQ] = st.receive_irq_flag;
        end
        uabw_pkg::OFS_EV_STATUS: begin
          next_st.rdata[uabw_pkg::EV_W-1:0] = st.ev_status;
        end
        uabw_pkg::OFS_EV_ENABLE: begin
          next_st.rdata[uabw_pkg::EV_W-1:0] = st.ev_enable;
        end
        uabw_pkg::OFS_EV_CLEAR: begin
          next_st.rdata = 32'h0000_0000; // write-only, reads zero
        end
        default: begin
          next_st.rresp = uabw_pkg::RESP_SLVERR;
        end
      endcase
    end

    // receiver modes; hardware sets come after software clears
    unique case (st.mode)
      uabw_pkg::ST_IDLE: begin
        if (st.wake_on_break_enable & ~st.sync_mode) begin
          next_st.mode = uabw_pkg::ST_WAKE;
        end else if (st.autobaud_enable & ~st.sync_mode & run) begin
          next_st.mode = uabw_pkg::ST_ABD;
          next_st.abd_started = 1'b0;
          next_st.rise_cnt = 3'h0;
          next_st.abd_count = 16'h0000;
        end else if (rx_fall & run & ~st.wake_on_break_enable) begin
          next_st.mode = uabw_pkg::ST_RECV;
          next_st.timer = {1'b0, st.divisor[15:1]};
          next_st.bit_idx = uabw_pkg::BIT_START;
        end
      end
      uabw_pkg::ST_WAKE: begin
        if (~st.wake_on_break_enable | st.sync_mode) begin
          next_st.mode = uabw_pkg::ST_IDLE;
        end else if (rx_fall) begin
          next_st.receive_irq_flag = 1'b1;
          ev[uabw_pkg::EV_WAKE] = 1'b1;
        end else if (rx_rise) begin
          next_st.wake_on_break_enable = 1'b0;
          next_st.mode = uabw_pkg::ST_IDLE;
        end
      end
      uabw_pkg::ST_ABD: begin
        if (~st.autobaud_enable) begin
          next_st.mode = uabw_pkg::ST_IDLE;
        end else if (run) begin
          if (!st.abd_started) begin
            next_st.abd_started = rx_fall;
          end else begin
            next_st.abd_count = st.abd_count + 16'h0001;
            if (st.abd_count == uabw_pkg::CNT_FULL) begin
              next_st.ovf = 1'b1;
              next_st.receive_irq_flag = 1'b1;
              ev[uabw_pkg::EV_OVF] = 1'b1;
            end
            if (rx_rise) begin
              if (st.rise_cnt == uabw_pkg::RISE_LAST) begin
                next_st.divisor = st.abd_count >> uabw_pkg::ABD_SHIFT;
                next_st.autobaud_enable = 1'b0;
                next_st.receive_irq_flag = 1'b1;
                next_st.mode = uabw_pkg::ST_IDLE;
                ev[uabw_pkg::EV_ABD] = 1'b1;
              end else begin
                next_st.rise_cnt = st.rise_cnt + 3'h1;
              end
            end
          end
        end
      end
      uabw_pkg::ST_RECV: begin
        if (~run | st.wake_on_break_enable) begin
          next_st.mode = uabw_pkg::ST_IDLE;
        end else if (st.timer != 16'h0000) begin
          next_st.timer = st.timer - 16'h0001;
        end else begin
          next_st.timer = st.divisor;
          next_st.bit_idx = st.bit_idx + 4'h1;
          if (st.bit_idx == uabw_pkg::BIT_START) begin
            if (st.rx_sync) begin
              next_st.mode = uabw_pkg::ST_IDLE; // glitch, no start bit
            end
          end else if (st.bit_idx == uabw_pkg::BIT_LAST) begin
            next_st.rx_data = st.shift;
            next_st.receive_irq_flag = 1'b1;
            ev[uabw_pkg::EV_RX] = 1'b1;
            next_st.mode = uabw_pkg::ST_IDLE;
          end else begin
            next_st.shift = {st.rx_sync, st.shift[7:1]};
          end
        end
      end
      default: begin
        next_st.mode = uabw_pkg::ST_IDLE;
      end
    endcase

    // sticky events: a set in the clear cycle wins
    next_st.ev_status = (st.ev_status & ~ev_clr) | ev;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '{mode: uabw_pkg::ST_IDLE, rx_meta: 1'b1, rx_sync: 1'b1, rx_prev: 1'b1,
              divisor: uabw_pkg::DIV_RESET, bresp: uabw_pkg::RESP_OKAY,
              rresp: uabw_pkg::RESP_OKAY, default: '0};
    end else if (mclk_en) begin
      st <= next_st;
    end
  end

endmodule

// file: design/uabw_pkg.sv
package uabw_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_DATA = 8'h04;
  localparam logic [7:0] OFS_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_RX_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EV_STATUS = 8'h14;
  localparam logic [7:0] OFS_EV_CLEAR = 8'h18;
  localparam logic [7:0] OFS_EV_ENABLE = 8'h1C;

  // baud_control_status field positions
  localparam int unsigned BC_OVF = 7;
  localparam int unsigned BC_IDLE = 6;
  localparam int unsigned BC_WUE = 1;
  localparam int unsigned BC_AUTOBAUD_ENABLE = 0;
  // mode register and receive flag register fields
  localparam int unsigned MODE_SYNC = 0;
  localparam int unsigned RXF_IRQ = 0;

  // event bits of status, clear and enable registers
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_RX = 0;
  localparam int unsigned EV_OVF = 1;
  localparam int unsigned EV_WAKE = 2;
  localparam int unsigned EV_ABD = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values and counts
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam int unsigned ABD_SHIFT = 3;
  localparam logic [2:0] RISE_LAST = 3'h4;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] BIT_START = 4'h0;

  // receiver modes
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ABD = 4'h2,
    ST_WAKE = 4'h4,
    ST_RECV = 4'h8
  } uabw_mode_type;

  // axi4-lite master to slave
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } uabw_axi_req_type;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } uabw_axi_rsp_type;

endpackage

// file: tb/uabw_core_checker.sv
`timescale 1ns/1ps
module uabw_core_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic mclk_en,
  input wire uabw_pkg::uabw_axi_req_type axi_in,
  input wire uabw_pkg::uabw_axi_rsp_type axi_out,
  input wire logic rx_pin,
  input wire logic sleep_mode,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // taking edges of the two request channels
  sequence wr_take;
    axi_in.awvalid && axi_in.wvalid && axi_out.awready;
  endsequence
  sequence rd_take;
    axi_in.arvalid && axi_out.arready;
  endsequence
  // response timing and holding
  wr_resp_next_a: assert property (wr_take |=> axi_out.bvalid) else $error("write response late");
  rd_resp_next_a: assert property (rd_take |=> axi_out.rvalid) else $error("read response late");
  wr_resp_hold_a: assert property (axi_out.bvalid && !axi_in.bready |=> axi_out.bvalid && $stable(axi_out.bresp))
    else $error("write response dropped");
  rd_resp_hold_a: assert property (axi_out.rvalid && !axi_in.rready |=> axi_out.rvalid && $stable(axi_out.rdata))
    else $error("read data dropped");
  rd_block_a: assert property (axi_out.rvalid |-> !axi_out.arready) else $error("read taken while busy");
  wr_pair_a: assert property (axi_out.awready |-> axi_in.awvalid && axi_in.wvalid && axi_out.wready && !axi_out.bvalid)
    else $error("write channels split");
  err_zero_a: assert property (axi_out.rvalid && axi_out.rresp == uabw_pkg::RESP_SLVERR |-> axi_out.rdata == 32'h0000_0000)
    else $error("error read carries data");
  en_freeze_a: assert property (!mclk_en |-> !axi_out.awready && !axi_out.arready) else $error("ready while frozen");
  freeze_hold_a: assert property (!mclk_en |=> $stable(irq) && $stable(axi_out.bvalid) && $stable(axi_out.rvalid))
    else $error("state moved while frozen");
endmodule
bind uabw_core uabw_core_checker chk (.mclk(mclk), .sys_rst(sys_rst), .mclk_en(mclk_en), .axi_in(axi_in),
  .axi_out(axi_out), .rx_pin(rx_pin), .sleep_mode(sleep_mode), .irq(irq));

// file: tb/uabw_rx_node.sv
`timescale 1ns/1ps
module uabw_rx_node (
  input wire logic mclk,
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  // hold the line at one level for n cycles
  task automatic drive(input logic v, input int n);
    rx_pin <= v;
    repeat (n) @(posedge mclk);
  endtask
  // 8n1 frame, lsb first, line back high after stop
  task automatic frame(input logic [7:0] b, input int bt);
    drive(1'b0, bt);
    for (int i = 0; i < 8; i++) drive(b[i], bt);
    drive(1'b1, bt);
  endtask
endmodule

// file: tb/uabw_core_tb.sv
`timescale 1ns/1ps
module uabw_core_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic mclk_en = 1'b1;
  logic sleep_mode = 1'b0;
  logic irq;
  logic rx_pin;
  uabw_pkg::uabw_axi_req_type req = '0;
  uabw_pkg::uabw_axi_rsp_type rsp;
  logic [31:0] rdat;
  logic [1:0] rres;
  logic [1:0] wres;
  int bad_count = 0;
  int checks_done = 0;
  // 200 mhz clock
  always #2.5 mclk = ~mclk;
  uabw_core dut (.mclk(mclk), .sys_rst(sys_rst), .mclk_en(mclk_en), .axi_in(req), .axi_out(rsp),
    .rx_pin(rx_pin), .sleep_mode(sleep_mode), .irq(irq));
  uabw_rx_node node (.mclk(mclk), .rx_pin(rx_pin));
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // axi4-lite write, both channels offered together, each released on its own ready
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= 32'(d);
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge mclk);
      if (aw_open && rsp.awready === 1'b1) begin
        aw_open = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w_open && rsp.wready === 1'b1) begin
        w_open = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge mclk);
    req.bready <= 1'b0;
    wres = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge mclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge mclk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rdat = rsp.rdata;
    rres = rsp.rresp;
  endtask
  // read and compare the masked bits
  task automatic rc(input string n, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    rd(a);
    chk(n, rdat & 32'(m), 32'(e));
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rc("baud_ctrl", uabw_pkg::OFS_BAUD_CTRL, 16'h00C3, 16'h0040);
    chk("rd_okay", 32'(rres), 32'(uabw_pkg::RESP_OKAY));
    rd(8'h20);
    chk("unmapped_resp", 32'(rres), 32'(uabw_pkg::RESP_SLVERR));
    chk("unmapped_data", rdat, 32'h0000_0000);
    wr(8'h20, 16'h00FF);
    chk("unmapped_wr", 32'(wres), 32'(uabw_pkg::RESP_SLVERR));
    wr(uabw_pkg::OFS_EV_ENABLE, 16'h000F);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0001);
    node.frame(8'h55, 40);
    rc("abd_done", uabw_pkg::OFS_BAUD_CTRL, 16'h00C3, 16'h0040);
    chk("irq_on", irq, 1'b1);
    wr(uabw_pkg::OFS_EV_CLEAR, 16'h000F);
    rd(uabw_pkg::OFS_RX_DATA);
    chk("irq_off", irq, 1'b0);
    // slow sync character: counter passes 16 bits before the fifth rise
    wr(uabw_pkg::OFS_EV_ENABLE, 16'h0002);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0001);
    fork
      node.frame(8'h55, 7400);
      begin
        wait (irq === 1'b1);
        rc("ovf_set", uabw_pkg::OFS_BAUD_CTRL, 16'h00C1, 16'h0081);
        rc("ovf_receive_irq_flag", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0001);
        rd(uabw_pkg::OFS_RX_DATA);
        rc("receive_irq_flag_read", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0000);
      end
    join
    rc("ovf_fifth", uabw_pkg::OFS_BAUD_CTRL, 16'h00C1, 16'h00C0);
    rc("receive_irq_flag_again", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0001);
    rd(uabw_pkg::OFS_RX_DATA);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0080);
    rc("ovf_w1", uabw_pkg::OFS_BAUD_CTRL, 16'h0080, 16'h0080);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0000);
    rc("ovf_clr", uabw_pkg::OFS_BAUD_CTRL, 16'h0080, 16'h0000);
    wr(uabw_pkg::OFS_EV_CLEAR, 16'h000F);
    // bit time of 40 cycles from here on
    wr(uabw_pkg::OFS_DIVISOR, 16'h0027);
    chk("wr_okay", 32'(wres), 32'(uabw_pkg::RESP_OKAY));
    rc("divisor", uabw_pkg::OFS_DIVISOR, 16'hFFFF, 16'h0027);
    // clock enable low holds a read off until it rises
    mclk_en <= 1'b0;
    fork
      rc("frozen_rd", uabw_pkg::OFS_DIVISOR, 16'hFFFF, 16'h0027);
      begin
        repeat (4) @(posedge mclk);
        chk("frozen_ar", rsp.arready, 1'b0);
        mclk_en <= 1'b1;
      end
    join
    // wake on break while asleep, break of 13 bit times
    wr(uabw_pkg::OFS_EV_ENABLE, 16'h0004);
    rc("idle_pre_wake", uabw_pkg::OFS_BAUD_CTRL, 16'h0040, 16'h0040);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0002);
    sleep_mode <= 1'b1;
    fork
      node.drive(1'b0, 520);
      begin
        wait (irq === 1'b1);
        rc("wake_receive_irq_flag", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0001);
        rc("wake_hold", uabw_pkg::OFS_BAUD_CTRL, 16'h0003, 16'h0002);
      end
    join
    node.drive(1'b1, 8);
    rc("wue_clr", uabw_pkg::OFS_BAUD_CTRL, 16'h0003, 16'h0000);
    rd(uabw_pkg::OFS_RX_DATA);
    rc("wake_read", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0000);
    wr(uabw_pkg::OFS_EV_CLEAR, 16'h0004);
    repeat (2) @(posedge mclk);
    chk("irq_clr", irq, 1'b0);
    // no reception while asleep, ordinary reception when awake
    node.frame(8'hA5, 40);
    rc("sleep_rx", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0000);
    sleep_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    node.frame(8'hA5, 40);
    rc("rx_byte", uabw_pkg::OFS_RX_DATA, 16'h00FF, 16'h00A5);
    // detection cancelled after one edge pair: the next fall starts a byte
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0001);
    node.drive(1'b0, 40);
    node.drive(1'b1, 40);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0000);
    node.frame(8'h3C, 40);
    rc("abd_cancel", uabw_pkg::OFS_RX_DATA, 16'h00FF, 16'h003C);
    // wake armed while awake: first low is the wake, the rest a fragment
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0002);
    node.frame(8'h02, 40);
    node.drive(1'b1, 120);
    rc("frag_wue", uabw_pkg::OFS_BAUD_CTRL, 16'h0002, 16'h0000);
    rc("frag_byte", uabw_pkg::OFS_RX_DATA, 16'h00FF, 16'h00E0);
    // synchronous mode ignores a break
    wr(uabw_pkg::OFS_MODE, 16'h0001);
    wr(uabw_pkg::OFS_BAUD_CTRL, 16'h0002);
    node.drive(1'b0, 100);
    node.drive(1'b1, 8);
    rc("sync_wake", uabw_pkg::OFS_RX_FLAGS, 16'h0001, 16'h0000);
    stop_test;
  end
  // hang guard
  initial begin
    repeat (95000) @(posedge mclk);
    bad_count++;
    stop_test;
  end
endmodule
